// ### logic/spp_pkg.sv
// Constants shared by the shared parallel I/O port design
package spp_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_DIRECTION  = 8'h00;
    localparam logic [7:0] OFS_OUT_LATCH  = 8'h04;
    localparam logic [7:0] OFS_PIN_LEVEL  = 8'h08;
    localparam logic [7:0] OFS_OPEN_DRAIN = 8'h0C;
    localparam logic [7:0] OFS_ANALOG_SEL = 8'h10;
    localparam logic [7:0] OFS_USB_CFG2   = 8'h14;
    // Field position of the transceiver disable bit
    localparam int         TRANS_DIS_BIT  = 0;
    // AXI responses
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;
    // Reset values
    localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
    localparam logic        USB_CFG_RST   = 1'b0;
    // Defaults of the port shape
    localparam int          PORT_W        = 16;
    localparam logic [31:0] IMPL_DEF      = 32'h0000_FFFF;
    localparam logic [31:0] ANALOG_DEF    = 32'h0000_00CF;
    localparam int          DPLUS_DEF     = 2;
    localparam int          DMINUS_DEF    = 3;
endpackage

// ### logic/spp_sync.sv
// Two flip-flop synchroniser for the pad input levels
`timescale 1ns/1ps
module spp_sync #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rstn,
    // Levels in and out
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // First stage read only by the second
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// ### logic/spp_port.sv
// Shared parallel I/O port with AXI4-Lite register access
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// R1 - Enabled driving peripheral owns pin output data and enable over port bit
// R2 - Port's own driven output never loops back into peripheral input
// R3 - Peripheral driving: port driver off, pin level still readable
// R4 - Peripheral enabled but not driving: port bit may drive pin
// R5 - Direction one makes pin input; zero drives it from output latch
// R6 - Reset sets every direction bit, all pins inputs
// R7 - Latch register reads stored latch, writes update latch
// R8 - Pin register reads sampled pins; writes go to output latch
// R9 - Unimplemented bits disabled; latch, direction, pin read zero
// R10 - Software waits one instruction cycle between port change and read
// R11 - Per-pin open-drain bit makes output open-drain
// R12 - USB data pin input buffers off unless transceiver disable set; code gates only the pin register, periph_in still sees D+ and D-
// R13 - Analog-select bit per analog pin chooses analog or digital
// R14 - Analog input pins read zero in pin register
// R15 - Analog-select one: analog, readback off; implemented bits reset one
// R16 - Software clears analog-select and direction for digital output
// R17 - Open-drain drives low for zero, floats for one
// R18 - Pin readback passes registered synchroniser into clock domain
module spp_port #(
    parameter int          W         = spp_pkg::PORT_W,
    parameter logic [31:0] IMPL_MASK = spp_pkg::IMPL_DEF,
    parameter logic [31:0] ANA_MASK  = spp_pkg::ANALOG_DEF,
    parameter int          DP_IDX    = spp_pkg::DPLUS_DEF,
    parameter int          DM_IDX    = spp_pkg::DMINUS_DEF
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rstn,
    // AXI4-Lite write address and data
    input  wire logic [7:0]   s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]   s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready,
    // Peripheral side of the pins
    input  wire logic [W-1:0] periph_en,
    input  wire logic [W-1:0] periph_drive,
    input  wire logic [W-1:0] periph_out,
    output logic [W-1:0]      periph_in,
    // Pads
    input  wire logic [W-1:0] pad_i,
    output logic [W-1:0]      pad_o,
    output logic [W-1:0]      pad_oe
);
    localparam logic [W-1:0] IMPL = IMPL_MASK[W-1:0];
    localparam logic [W-1:0] ANA  = ANA_MASK[W-1:0] & IMPL_MASK[W-1:0];

    // Byte-lane merge used by every register write except OFS_USB_CFG2, which takes TRANS_DIS_BIT alone
    function automatic logic [W-1:0] merge(input logic [W-1:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0] strb);
        logic [31:0] res;
        res = {{(32-W){1'b0}}, old};
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return res[W-1:0];
    endfunction

    // Address decode used by write and read paths
    function automatic logic mapped(input logic [7:0] a);
        return a == spp_pkg::OFS_DIRECTION || a == spp_pkg::OFS_OUT_LATCH ||
               a == spp_pkg::OFS_PIN_LEVEL || a == spp_pkg::OFS_OPEN_DRAIN ||
               a == spp_pkg::OFS_ANALOG_SEL || a == spp_pkg::OFS_USB_CFG2;
    endfunction

    logic [W-1:0] dir_q, latch_q, od_q, ana_q;
    logic [W-1:0] dir_d, latch_d, od_d, ana_d;
    logic         trans_dis_q, trans_dis_d;
    logic         aw_hold_q, w_hold_q;
    logic [7:0]   awaddr_q, rd_addr_q;
    logic [31:0]  wdata_q;
    logic [3:0]   wstrb_q;
    logic [W-1:0] pin_sync;
    logic [W-1:0] owner_w, port_drive_w, buf_en_w, pin_level_w;
    logic [W-1:0] pad_o_d, pad_oe_d;
    logic [31:0]  rd_mux;
    logic         do_wr, aw_take, w_take, ar_take;

    // Pad levels into the clock domain
    spp_sync #(.W(W)) u_sync (                              // [R18]
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .async_in (pad_i),
        .sync_out (pin_sync)
    );

    // Ownership, port drive and input buffer enables
    assign owner_w      = periph_en & periph_drive;        // [R1] [R3] [R4]
    assign port_drive_w = ~dir_q & IMPL & ~owner_w;         // [R5] [R3] [R4]
    assign buf_en_w     = ~(((W'(1) << DP_IDX) | (W'(1) << DM_IDX)) &
                          {W{~trans_dis_q}});               // [R12]
    assign pin_level_w  = pin_sync & IMPL & ~ana_q & buf_en_w; // [R9] [R14] [R15]

    // Pad drive: peripheral first, else latch, open-drain floats ones
    assign pad_o_d  = (owner_w & periph_out) |
                      (~owner_w & ~od_q & latch_q);         // [R1] [R17]
    assign pad_oe_d = owner_w |
                      (port_drive_w & (~od_q | ~latch_q));  // [R11] [R17]

    // Bus handshakes
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take  = s_axi_wvalid & s_axi_wready;
    assign ar_take = s_axi_arvalid & s_axi_arready;
    assign do_wr   = aw_hold_q & w_hold_q & ~s_axi_bvalid;

    // Register next values from a write
    assign dir_d = (do_wr && awaddr_q == spp_pkg::OFS_DIRECTION) ?
                   merge(dir_q, wdata_q, wstrb_q) & IMPL : dir_q;        // [R5] [R9]
    assign latch_d = (do_wr && (awaddr_q == spp_pkg::OFS_OUT_LATCH ||
                                awaddr_q == spp_pkg::OFS_PIN_LEVEL)) ?
                     merge(latch_q, wdata_q, wstrb_q) & IMPL : latch_q;  // [R7] [R8]
    assign od_d = (do_wr && awaddr_q == spp_pkg::OFS_OPEN_DRAIN) ?
                  merge(od_q, wdata_q, wstrb_q) & IMPL : od_q;           // [R11]
    assign ana_d = (do_wr && awaddr_q == spp_pkg::OFS_ANALOG_SEL) ?
                   merge(ana_q, wdata_q, wstrb_q) & ANA : ana_q;         // [R13]
    assign trans_dis_d = (do_wr && awaddr_q == spp_pkg::OFS_USB_CFG2 &&
                          wstrb_q[spp_pkg::TRANS_DIS_BIT / 8]) ?
                         wdata_q[spp_pkg::TRANS_DIS_BIT] : trans_dis_q;

    // Read data selection
    assign rd_mux =
        (s_axi_araddr == spp_pkg::OFS_DIRECTION)  ? 32'(dir_q)       :
        (s_axi_araddr == spp_pkg::OFS_OUT_LATCH)  ? 32'(latch_q)     : // [R7]
        (s_axi_araddr == spp_pkg::OFS_PIN_LEVEL)  ? 32'(pin_level_w) : // [R8]
        (s_axi_araddr == spp_pkg::OFS_OPEN_DRAIN) ? 32'(od_q)        :
        (s_axi_araddr == spp_pkg::OFS_ANALOG_SEL) ? 32'(ana_q)       :
        (s_axi_araddr == spp_pkg::OFS_USB_CFG2)   ? 32'(trans_dis_q) :
        spp_pkg::ZERO_WORD;

    // Port configuration registers
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dir_q       <= IMPL;                            // [R6]
            latch_q     <= '0;
            od_q        <= '0;
            ana_q       <= ANA;                             // [R15]
            trans_dis_q <= spp_pkg::USB_CFG_RST;            // [R12]
        end else begin
            dir_q       <= dir_d;
            latch_q     <= latch_d;
            od_q        <= od_d;
            ana_q       <= ana_d;
            trans_dis_q <= trans_dis_d;
        end
    end

    // Pad and peripheral outputs
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pad_o     <= '0;
            pad_oe    <= '0;
            periph_in <= '0;
        end else begin
            pad_o     <= pad_o_d;
            pad_oe    <= pad_oe_d;
            periph_in <= pin_sync & ~port_drive_w;          // [R2]
        end
    end

    // Write address and data capture, either order
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            aw_hold_q     <= 1'b0;
            w_hold_q      <= 1'b0;
            awaddr_q      <= '0;
            wdata_q       <= spp_pkg::ZERO_WORD;
            wstrb_q       <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end else if (do_wr) begin
                aw_hold_q <= 1'b0;
            end
            if (w_take) begin
                w_hold_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end else if (do_wr) begin
                w_hold_q <= 1'b0;
            end
            s_axi_awready <= ~aw_take & ~aw_hold_q & ~s_axi_bvalid;
            s_axi_wready  <= ~w_take & ~w_hold_q & ~s_axi_bvalid;
        end
    end

    // Write response
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= spp_pkg::RESP_OKAY;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(awaddr_q) ? spp_pkg::RESP_OKAY : spp_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read channel
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= spp_pkg::ZERO_WORD;
            s_axi_rresp   <= spp_pkg::RESP_OKAY;
            rd_addr_q     <= '0;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= mapped(s_axi_araddr) ? spp_pkg::RESP_OKAY : spp_pkg::RESP_SLVERR;
            rd_addr_q     <= s_axi_araddr;
        end else if (s_axi_rvalid) begin
            s_axi_rvalid  <= ~s_axi_rready;
            s_axi_arready <= s_axi_rready;
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // Checks on the port behaviour
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    property p_owner_drives;
        ##1 1'b1 |-> (($past(owner_w) & ~pad_oe) == '0) &&
                     (($past(owner_w) & (pad_o ^ $past(periph_out))) == '0);
    endproperty
    a_owner_drives: assert property (p_owner_drives) else $error("peripheral lost pin"); // [R1]

    property p_no_loop;
        ##1 1'b1 |-> (($past(port_drive_w) & periph_in) == '0);
    endproperty
    a_no_loop: assert property (p_no_loop) else $error("port output looped to peripheral"); // [R2]

    property p_inputs_float;
        (dir_q == IMPL && owner_w == '0) |=> pad_oe == '0;
    endproperty
    a_inputs_float: assert property (p_inputs_float) else $error("input pin driven"); // [R5]

    property p_latch_read;
        (ar_take && s_axi_araddr == spp_pkg::OFS_OUT_LATCH) |=>
            s_axi_rvalid && s_axi_rdata == 32'($past(latch_q));
    endproperty
    a_latch_read: assert property (p_latch_read) else $error("latch read wrong"); // [R7]

    property p_pin_write;
        (do_wr && awaddr_q == spp_pkg::OFS_PIN_LEVEL && wstrb_q == 4'hF) |=>
            latch_q == ($past(wdata_q[W-1:0]) & IMPL);
    endproperty
    a_pin_write: assert property (p_pin_write) else $error("pin write missed latch"); // [R8]

    property p_unimpl_zero;
        ((dir_q | latch_q | pin_level_w | od_q) & ~IMPL) == '0;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set"); // [R9]

    property p_open_drain;
        ##1 1'b1 |-> (($past(od_q & port_drive_w & latch_q) & pad_oe) == '0) &&
                     (($past(od_q & ~owner_w) & pad_o) == '0);
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open-drain drove high"); // [R17]

    property p_analog_zero;
        (pin_level_w & ana_q) == '0;
    endproperty
    a_analog_zero: assert property (p_analog_zero) else $error("analog pin read nonzero"); // [R14]

    property p_usb_buffer;
        !trans_dis_q |-> !pin_level_w[DP_IDX] && !pin_level_w[DM_IDX];
    endproperty
    a_usb_buffer: assert property (p_usb_buffer) else $error("usb buffer not disabled"); // [R12]

    property p_sync_delay;
        ##2 (pad_i == $past(pad_i) && $past(pad_i) == $past(pad_i, 2)) |-> pin_sync == pad_i;
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("sync latency wrong"); // [R18]

    c_write_done: cover property (do_wr ##[1:4] s_axi_bvalid && s_axi_bready);
    c_periph_take: cover property ((owner_w & ~dir_q & IMPL) != '0);
    c_od_float: cover property ((od_q & port_drive_w & latch_q) != '0);
    c_pin_read: cover property (ar_take && s_axi_araddr == spp_pkg::OFS_PIN_LEVEL);
endmodule

// ### dv/spp_pad_model.sv
// Pad model: port drive, external driver, otherwise pull-up
`timescale 1ns/1ps
module spp_pad_model #(
    parameter int W = 16
) (
    // Port side of the pads
    input  wire logic [W-1:0] pad_o,
    input  wire logic [W-1:0] pad_oe,
    // External driver
    input  wire logic [W-1:0] ext_en,
    input  wire logic [W-1:0] ext_val,
    // Level seen at the pads
    output logic [W-1:0]      pad_i
);
    // Released pads with no external driver float up through the pull-up
    assign pad_i = (pad_oe & pad_o) | (~pad_oe & ext_en & ext_val) | (~pad_oe & ~ext_en);
endmodule

// ### dv/tb_spp_port.sv
// Self-checking bench for the shared parallel I/O port
`timescale 1ns/1ps
module tb_spp_port;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [15:0] periph_en = 16'h0000, periph_drive = 16'h0000, periph_out = 16'h0000;
    logic [15:0] ext_en = 16'h0000, ext_val = 16'h0000;
    logic [15:0] periph_in, pad_i, pad_o, pad_oe;
    int          bad_count = 0;
    int          cmp_count = 0;

    // Clock of 100 ns period
    always #50 ref_clk = ~ref_clk;

    spp_port dut (.ref_clk(ref_clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .periph_en(periph_en),
        .periph_drive(periph_drive), .periph_out(periph_out), .periph_in(periph_in),
        .pad_i(pad_i), .pad_o(pad_o), .pad_oe(pad_oe));

    spp_pad_model #(.W(16)) pads (.pad_o(pad_o), .pad_oe(pad_oe), .ext_en(ext_en),
        .ext_val(ext_val), .pad_i(pad_i));

    // Compare and report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Write with address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, spp_pkg::RESP_OKAY});
    endtask

    // Read and compare data and response
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rsp);
        @(posedge ref_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, exp);
        chk({30'h0, s_axi_rresp}, {30'h0, rsp});
    endtask

    // Let pad and synchroniser paths settle
    task automatic settle();
        repeat (4) @(posedge ref_clk);
        #1;
    endtask

    // Reset values and an unmapped place
    task automatic t_reset();
        rd(spp_pkg::OFS_DIRECTION, 32'h0000_FFFF, spp_pkg::RESP_OKAY);
        rd(spp_pkg::OFS_OUT_LATCH, 32'h0000_0000, spp_pkg::RESP_OKAY);
        rd(spp_pkg::OFS_ANALOG_SEL, 32'h0000_00CF, spp_pkg::RESP_OKAY);
        rd(spp_pkg::OFS_OPEN_DRAIN, 32'h0000_0000, spp_pkg::RESP_OKAY);
        rd(spp_pkg::OFS_USB_CFG2, 32'h0000_0000, spp_pkg::RESP_OKAY);
        rd(8'h18, 32'h0000_0000, spp_pkg::RESP_SLVERR);
        chk({16'h0, pad_oe}, 32'h0000_0000);
    endtask

    // Latch access, pin register write, missing upper bits
    task automatic t_latch();
        wr(spp_pkg::OFS_OUT_LATCH, 32'hFFFF_FFFF);
        rd(spp_pkg::OFS_OUT_LATCH, 32'h0000_FFFF, spp_pkg::RESP_OKAY);
        wr(spp_pkg::OFS_PIN_LEVEL, 32'h0000_5A3C);
        rd(spp_pkg::OFS_OUT_LATCH, 32'h0000_5A3C, spp_pkg::RESP_OKAY);
    endtask

    // Digital output with USB pins gated until transceiver disable
    task automatic t_output();
        wr(spp_pkg::OFS_ANALOG_SEL, 32'h0000_0000);
        wr(spp_pkg::OFS_DIRECTION, 32'h0000_0000);
        settle();
        chk({pad_oe, pad_o}, 32'hFFFF_5A3C);
        rd(spp_pkg::OFS_PIN_LEVEL, 32'h0000_5A30, spp_pkg::RESP_OKAY);
        wr(spp_pkg::OFS_USB_CFG2, 32'h0000_0001);
        rd(spp_pkg::OFS_PIN_LEVEL, 32'h0000_5A3C, spp_pkg::RESP_OKAY);
    endtask

    // Open-drain: low driven, high released
    task automatic t_open_drain();
        wr(spp_pkg::OFS_OPEN_DRAIN, 32'h0000_FFFF);
        settle();
        chk({pad_oe, pad_o}, 32'hA5C3_0000);
        rd(spp_pkg::OFS_PIN_LEVEL, 32'h0000_5A3C, spp_pkg::RESP_OKAY);
    endtask

    // Peripheral ownership and loop-through blocking
    task automatic t_periph();
        wr(spp_pkg::OFS_OPEN_DRAIN, 32'h0000_0000);
        wr(spp_pkg::OFS_OUT_LATCH, 32'h0000_0000);
        @(posedge ref_clk);
        periph_en    <= 16'h0003;
        periph_drive <= 16'h0001;
        periph_out   <= 16'h0001;
        settle();
        chk({pad_oe, pad_o}, 32'hFFFF_0001);
        chk({16'h0, periph_in}, 32'h0000_0001);
        rd(spp_pkg::OFS_PIN_LEVEL, 32'h0000_0001, spp_pkg::RESP_OKAY);
        @(posedge ref_clk);
        periph_en <= 16'h0000;
    endtask

    // Analog inputs read low; readback follows pad changes
    task automatic t_analog();
        wr(spp_pkg::OFS_DIRECTION, 32'h0000_FFFF);
        ext_en  <= 16'hFFFF;
        ext_val <= 16'hFFFF;
        wr(spp_pkg::OFS_ANALOG_SEL, 32'h0000_00F0);
        chk({16'h0, pad_oe}, 32'h0000_0000);
        rd(spp_pkg::OFS_PIN_LEVEL, 32'h0000_FF3F, spp_pkg::RESP_OKAY);
        ext_val <= 16'h12F4;
        @(posedge ref_clk);
        rd(spp_pkg::OFS_PIN_LEVEL, 32'h0000_1234, spp_pkg::RESP_OKAY);
    endtask

    // Mid-run reset returns driven pins to inputs
    task automatic t_rerst();
        wr(spp_pkg::OFS_DIRECTION, 32'h0000_0000);
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        #1;
        chk({16'h0, pad_oe}, 32'h0000_0000);
        rd(spp_pkg::OFS_DIRECTION, 32'h0000_FFFF, spp_pkg::RESP_OKAY);
        rd(spp_pkg::OFS_ANALOG_SEL, 32'h0000_00CF, spp_pkg::RESP_OKAY);
    endtask

    // Verdict and end of run
    task automatic wrap_up();
        if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset();
        t_latch();
        t_output();
        t_open_drain();
        t_periph();
        t_analog();
        t_rerst();
        wrap_up();
    end

    // Watchdog
    initial begin
        repeat (5000) @(posedge ref_clk);
        bad_count++;
        wrap_up();
    end
endmodule
